// >>> pkg/smwio_defs.vh
// constants for the wait/in/out executor of one i/o state machine
// assumes a 200 MHz single clock and a 32-entry instruction store outside
//
// Operation
// - 16-bit instructions, one cycle unless stalled
// - low delay bits are five minus side-set
// - wait delay counts only after condition met
// - wait polarity level; gpio, pin, irq sources
// - gpio source uses absolute gpio index
// - pin source is input base plus index
// - irq wait for one clears the flag
// - relative irq adds machine number modulo four
// - in shifts count bits, count saturates 32
// - bit count zero means thirty-two
// - autopush at threshold, stall when fifo full
// - autopush zeroes shift register and count
// - in takes low bits, shifts then fills
// - input bit order independent of direction
// - out shifts count bits, count saturates 32
// - out destinations decoded including execute target
// - out value low bits, zero upper bits
// - pin destinations use output pin mapping
// - autopull refills, zeroes count, stalls if empty
// - execute target runs word next cycle
// - program counter destination jumps unconditionally
`ifndef SMWIO_DEFS_VH
`define SMWIO_DEFS_VH
// ----------------------------------------
// register word indices (byte offset divided by four)
// ----------------------------------------
`define SMWIO_REG_CONFIG 6'h00
`define SMWIO_REG_PINCFG 6'h01
`define SMWIO_REG_THRESH 6'h02
`define SMWIO_REG_STATUS 6'h03
`define SMWIO_REG_SCRATCH_X 6'h04
`define SMWIO_REG_SCRATCH_Y 6'h05
`define SMWIO_REG_ISR 6'h06
`define SMWIO_REG_OSR 6'h07
`define SMWIO_REG_PIN_DATA 6'h08
`define SMWIO_REG_PIN_DIR 6'h09
// ----------------------------------------
// opcodes and field codes
// ----------------------------------------
`define SMWIO_OP_WAIT 3'h1
`define SMWIO_OP_IN 3'h2
`define SMWIO_OP_OUT 3'h3
`define SMWIO_WSRC_GPIO 2'h0
`define SMWIO_WSRC_PIN 2'h1
`define SMWIO_WSRC_IRQ 2'h2
`define SMWIO_SRC_PINS 3'h0
`define SMWIO_SRC_X 3'h1
`define SMWIO_SRC_Y 3'h2
`define SMWIO_SRC_NULL 3'h3
`define SMWIO_SRC_ISR 3'h6
`define SMWIO_SRC_OSR 3'h7
`define SMWIO_DST_PINS 3'h0
`define SMWIO_DST_X 3'h1
`define SMWIO_DST_Y 3'h2
`define SMWIO_DST_NULL 3'h3
`define SMWIO_DST_PINDIR 3'h4
`define SMWIO_DST_PC 3'h5
`define SMWIO_DST_ISR 3'h6
`define SMWIO_DST_EXECUTE_TARGET 3'h7
`define SMWIO_FULL_COUNT 7'h20
`define SMWIO_OSR_COUNT_RESET 6'h20
`define SMWIO_MAX_SIDESET 3'h5
`endif

// >>> hw/smwio_execute_target.v
// wait, in and out executor of one i/o state machine, with apb config
// assumes instruction store, fifos and irq flag set run on the same clock;
// gpio inputs are asynchronous and are synchronised here
`include "smwio_defs.vh"

module smwio_execute_target (
  input wire clock,
  input wire resetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  output wire [4:0] pc,
  input wire [15:0] instr,
  input wire [31:0] gpio_in,
  input wire [7:0] irq_flags,
  output reg [7:0] irq_clear,
  output reg [31:0] rx_data,
  output reg rx_push,
  input wire rx_full,
  input wire [31:0] tx_data,
  input wire tx_valid,
  output reg tx_pop,
  output reg [31:0] pin_data,
  output reg [31:0] pin_dir,
  output wire stalled
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_EXECUTE_TARGET = 3'b001;
  localparam ST_DELAY = 3'b010;
  localparam ST_HALT = 3'b100;

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // mask of the low n bits, n from 0 to 32
  function [31:0] low_mask;
    input [6:0] n;
    reg [63:0] t;
    begin
      t = (64'h0000_0000_0000_0001 << n) - 64'h0000_0000_0000_0001;
      low_mask = t[31:0];
    end
  endfunction

  // rotate left by r, used by the output pin mapping
  function [31:0] rotl;
    input [31:0] v;
    input [4:0] r;
    reg [63:0] t;
    begin
      t = {v, v} << r;
      rotl = t[63:32];
    end
  endfunction

  // bit count field: zero encodes thirty-two
  function [6:0] bit_count;
    input [4:0] f;
    begin
      bit_count = (f == 5'h00) ? `SMWIO_FULL_COUNT : {2'b00, f};
    end
  endfunction

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  reg cfg_enable;
  reg cfg_autopush;
  reg cfg_autopull;
  reg input_shift_direction; // 1 shifts right
  reg output_shift_direction; // 1 shifts right
  reg [2:0] cfg_sideset;
  reg [1:0] cfg_sm_num;
  reg [4:0] input_pin_base;
  reg [4:0] cfg_out_base;
  reg [5:0] cfg_out_count;
  reg [4:0] push_threshold;
  reg [4:0] pull_threshold;

  // ----------------------------------------
  // machine state
  // ----------------------------------------
  reg [2:0] state;
  reg [4:0] pc_reg;
  reg [4:0] delay_cnt;
  reg [31:0] scratch_x;
  reg [31:0] scratch_y;
  reg [31:0] input_shift_register;
  reg [31:0] output_shift_register;
  reg [5:0] isr_count;
  reg [5:0] osr_count;
  reg [15:0] execute_target_word;
  reg execute_target_pending;
  reg [31:0] gpio_meta;
  reg [31:0] gpio_sync;

  assign pc = pc_reg;

  // ----------------------------------------
  // gpio synchroniser
  // ----------------------------------------
  // two stages; only the second stage feeds decoding
  always @(posedge clock) begin
    if (!resetn) begin
      gpio_meta <= 32'h0000_0000;
      gpio_sync <= 32'h0000_0000;
    end else begin
      gpio_meta <= gpio_in;
      gpio_sync <= gpio_meta;
    end
  end

  // ----------------------------------------
  // decode and execute, combinational part
  // ----------------------------------------
  reg [15:0] cur;
  reg [2:0] op;
  reg [4:0] dly;
  reg [6:0] n;
  reg [31:0] mapped_in;
  reg [2:0] irq_idx;
  reg wait_bit;
  reg stall;
  reg [31:0] src;
  reg [31:0] isr_next;
  reg [6:0] isr_cnt_sum;
  reg [5:0] isr_cnt_next;
  reg [31:0] osr_cur;
  reg [5:0] osr_cnt_cur;
  reg [63:0] out_t;
  reg [31:0] out_val;
  reg [31:0] osr_next;
  reg [6:0] osr_cnt_sum;
  reg [6:0] push_lim;
  reg [6:0] pull_lim;
  reg do_push;
  reg need_pull;
  reg [63:0] in_t;
  reg [63:0] in_f;

  // the word taken from the data stream runs in place of the fetched one
  always @* begin
    cur = execute_target_pending ? execute_target_word : instr;
    op = cur[15:13];
    dly = cur[12:8] & (5'h1F >> cfg_sideset);
    n = bit_count(cur[4:0]);
    mapped_in = rotl(gpio_sync, 5'h00 - input_pin_base);
    // relative irq index: low two bits plus machine number, bit 2 kept
    irq_idx = cur[4] ? {cur[2], cur[1:0] + cfg_sm_num} : cur[2:0];
    push_lim = (push_threshold == 5'h00) ? `SMWIO_FULL_COUNT : {2'b00, push_threshold};
    pull_lim = (pull_threshold == 5'h00) ? `SMWIO_FULL_COUNT : {2'b00, pull_threshold};
    // wait source select
    case (cur[6:5])
      `SMWIO_WSRC_GPIO: wait_bit = gpio_sync[cur[4:0]];
      `SMWIO_WSRC_PIN: wait_bit = mapped_in[cur[4:0]];
      `SMWIO_WSRC_IRQ: wait_bit = irq_flags[irq_idx];
      default: wait_bit = cur[7]; // reserved source never stalls
    endcase
    // in source select
    case (cur[7:5])
      `SMWIO_SRC_PINS: src = mapped_in;
      `SMWIO_SRC_X: src = scratch_x;
      `SMWIO_SRC_Y: src = scratch_y;
      `SMWIO_SRC_ISR: src = input_shift_register;
      `SMWIO_SRC_OSR: src = output_shift_register;
      default: src = 32'h0000_0000; // null and reserved shift zeroes
    endcase
    // in: open a gap, then copy the low bits of the source into it
    in_t = 64'h0000_0000_0000_0000;
    in_f = {32'h0000_0000, src & low_mask(n)};
    if (input_shift_direction) begin
      in_t = {input_shift_register, 32'h0000_0000} >> n;
      in_f = in_f << (7'h20 - n); // lsb of data stays lowest
      isr_next = in_t[63:32] | in_f[31:0];
    end else begin
      in_t = {32'h0000_0000, input_shift_register} << n;
      isr_next = in_t[31:0] | in_f[31:0];
    end
    isr_cnt_sum = {1'b0, isr_count} + n;
    isr_cnt_next = (isr_cnt_sum > `SMWIO_FULL_COUNT) ? 6'h20 : isr_cnt_sum[5:0];
    do_push = cfg_autopush && ({1'b0, isr_cnt_next} >= push_lim);
    // out: an empty register at threshold is refilled first
    need_pull = cfg_autopull && ({1'b0, osr_count} >= pull_lim);
    osr_cur = need_pull ? tx_data : output_shift_register;
    osr_cnt_cur = need_pull ? 6'h00 : osr_count;
    if (output_shift_direction) begin
      out_val = osr_cur & low_mask(n);
      out_t = {32'h0000_0000, osr_cur} >> n;
      osr_next = out_t[31:0];
    end else begin
      out_t = {32'h0000_0000, osr_cur} << n;
      out_val = out_t[63:32];
      osr_next = out_t[31:0];
    end
    osr_cnt_sum = {1'b0, osr_cnt_cur} + n;
    // stall terms; a stalled cycle leaves pc, shift registers, counts and pins alone
    case (op)
      `SMWIO_OP_WAIT: stall = (wait_bit != cur[7]);
      `SMWIO_OP_IN: stall = do_push && (rx_full || rx_push);
      `SMWIO_OP_OUT: stall = need_pull && !tx_valid;
      default: stall = 1'b0;
    endcase
  end

  assign stalled = (state == ST_EXECUTE_TARGET) && stall;

  // irq clear and fifo pop are single-cycle strobes of any unstalled execute cycle, also one that disable turns into a halt
  always @* begin
    irq_clear = 8'h00;
    tx_pop = 1'b0;
    if (state == ST_EXECUTE_TARGET && !stall) begin
      if (op == `SMWIO_OP_WAIT && cur[6:5] == `SMWIO_WSRC_IRQ && cur[7])
        irq_clear[irq_idx] = 1'b1;
      if (op == `SMWIO_OP_OUT && need_pull)
        tx_pop = 1'b1;
    end
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  // zero wait states; read data captured in the setup cycle
  assign pready = 1'b1;
  wire apb_setup = psel && !penable;
  wire apb_write = psel && penable && pwrite;
  wire [5:0] widx = paddr[7:2];
  wire mapped = (widx <= `SMWIO_REG_PIN_DIR);

  always @(posedge clock) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      pslverr <= !mapped;
      case (widx)
        `SMWIO_REG_CONFIG: prdata <= {22'h00_0000, cfg_sm_num, cfg_sideset,
          output_shift_direction, input_shift_direction, cfg_autopull, cfg_autopush,
          cfg_enable};
        `SMWIO_REG_PINCFG: prdata <= {16'h0000, cfg_out_count, cfg_out_base, input_pin_base};
        `SMWIO_REG_THRESH: prdata <= {19'h0_0000, pull_threshold, 3'h0, push_threshold};
        `SMWIO_REG_STATUS: prdata <= {13'h0000, execute_target_pending, stalled, osr_count,
          isr_count, pc_reg};
        `SMWIO_REG_SCRATCH_X: prdata <= scratch_x;
        `SMWIO_REG_SCRATCH_Y: prdata <= scratch_y;
        `SMWIO_REG_ISR: prdata <= input_shift_register;
        `SMWIO_REG_OSR: prdata <= output_shift_register;
        `SMWIO_REG_PIN_DATA: prdata <= pin_data;
        `SMWIO_REG_PIN_DIR: prdata <= pin_dir;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // configuration writes; clamp side-set so the delay mask stays sane
  always @(posedge clock) begin
    if (!resetn) begin
      cfg_enable <= 1'b0;
      cfg_autopush <= 1'b0;
      cfg_autopull <= 1'b0;
      input_shift_direction <= 1'b1;
      output_shift_direction <= 1'b1;
      cfg_sideset <= 3'h0;
      cfg_sm_num <= 2'h0;
      input_pin_base <= 5'h00;
      cfg_out_base <= 5'h00;
      cfg_out_count <= 6'h00;
      push_threshold <= 5'h00;
      pull_threshold <= 5'h00;
    end else if (apb_write) begin
      if (widx == `SMWIO_REG_CONFIG) begin
        cfg_enable <= pwdata[0];
        cfg_autopush <= pwdata[1];
        cfg_autopull <= pwdata[2];
        input_shift_direction <= pwdata[3];
        output_shift_direction <= pwdata[4];
        cfg_sideset <= (pwdata[7:5] > `SMWIO_MAX_SIDESET) ? `SMWIO_MAX_SIDESET : pwdata[7:5];
        cfg_sm_num <= pwdata[9:8];
      end
      if (widx == `SMWIO_REG_PINCFG) begin
        input_pin_base <= pwdata[4:0];
        cfg_out_base <= pwdata[9:5];
        cfg_out_count <= (pwdata[15:10] > 6'h20) ? 6'h20 : pwdata[15:10];
      end
      if (widx == `SMWIO_REG_THRESH) begin
        push_threshold <= pwdata[4:0];
        pull_threshold <= pwdata[12:8];
      end
    end
  end

  // ----------------------------------------
  // sequencer and datapath registers
  // ----------------------------------------
  wire [31:0] pin_mask = rotl(low_mask({1'b0, cfg_out_count}), cfg_out_base);
  wire [31:0] pin_val = rotl(out_val, cfg_out_base);
  wire [4:0] pc_inc = pc_reg + 5'h01;

  // one clocked process so each shift register has a single writer;
  // software writes to x and y lose to a same-cycle instruction write
  always @(posedge clock) begin
    if (!resetn) begin
      state <= ST_HALT;
      pc_reg <= 5'h00;
      delay_cnt <= 5'h00;
      scratch_x <= 32'h0000_0000;
      scratch_y <= 32'h0000_0000;
      input_shift_register <= 32'h0000_0000;
      output_shift_register <= 32'h0000_0000;
      isr_count <= 6'h00;
      osr_count <= `SMWIO_OSR_COUNT_RESET;
      execute_target_word <= 16'h0000;
      execute_target_pending <= 1'b0;
      rx_push <= 1'b0;
      rx_data <= 32'h0000_0000;
      pin_data <= 32'h0000_0000;
      pin_dir <= 32'h0000_0000;
    end else begin
      rx_push <= 1'b0;
      if (apb_write && widx == `SMWIO_REG_SCRATCH_X)
        scratch_x <= pwdata;
      if (apb_write && widx == `SMWIO_REG_SCRATCH_Y)
        scratch_y <= pwdata;
      case (state)
        ST_HALT: begin
          if (cfg_enable)
            state <= ST_EXECUTE_TARGET;
        end
        ST_DELAY: begin
          // idle cycles after a completed instruction
          if (delay_cnt == 5'h01)
            state <= cfg_enable ? ST_EXECUTE_TARGET : ST_HALT;
          delay_cnt <= delay_cnt - 5'h01;
        end
        ST_EXECUTE_TARGET: begin
          if (!cfg_enable) begin
            state <= ST_HALT;
          end else if (!stall) begin
            // completes in this cycle; delay starts only now
            pc_reg <= pc_inc;
            execute_target_pending <= 1'b0;
            if (dly != 5'h00) begin
              state <= ST_DELAY;
              delay_cnt <= dly;
            end
            if (op == `SMWIO_OP_IN) begin
              if (do_push) begin
                rx_push <= 1'b1;
                rx_data <= isr_next;
                input_shift_register <= 32'h0000_0000;
                isr_count <= 6'h00;
              end else begin
                input_shift_register <= isr_next;
                isr_count <= isr_cnt_next;
              end
            end
            if (op == `SMWIO_OP_OUT) begin
              output_shift_register <= osr_next;
              osr_count <= (osr_cnt_sum > `SMWIO_FULL_COUNT) ? 6'h20 : osr_cnt_sum[5:0];
              case (cur[7:5])
                `SMWIO_DST_PINS: pin_data <= (pin_data & ~pin_mask) | (pin_val & pin_mask);
                `SMWIO_DST_X: scratch_x <= out_val;
                `SMWIO_DST_Y: scratch_y <= out_val;
                `SMWIO_DST_PINDIR: pin_dir <= (pin_dir & ~pin_mask) | (pin_val & pin_mask);
                `SMWIO_DST_PC: pc_reg <= out_val[4:0];
                `SMWIO_DST_ISR: begin
                  input_shift_register <= out_val;
                  isr_count <= n[5:0];
                end
                `SMWIO_DST_EXECUTE_TARGET: begin
                  // the out's own delay is dropped; the executee's counts
                  execute_target_word <= out_val[15:0];
                  execute_target_pending <= 1'b1;
                  state <= ST_EXECUTE_TARGET;
                  delay_cnt <= 5'h00;
                end
                default: begin
                end
              endcase
            end
          end
        end
        default: state <= ST_HALT;
      endcase
    end
  end

endmodule // smwio_execute_target

// >>> verification/smwio_execute_target_checker.sv
// assertions on the ports of the wait/in/out executor
// assumes one clock and a synchronous active-low reset
module smwio_execute_target_checker (
  input wire clock,
  input wire resetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pslverr,
  input wire [4:0] pc,
  input wire [7:0] irq_flags,
  input wire [7:0] irq_clear,
  input wire rx_push,
  input wire rx_full,
  input wire tx_valid,
  input wire tx_pop,
  input wire [31:0] pin_data,
  input wire stalled
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // bus and reset
  // ----------------------------------------
  chk_slverr_map: assert property (psel && penable |-> pslverr == (paddr[7:2] > 6'h09))
    else $error("error response does not match the address map");
  chk_reset_quiet: assert property (disable iff (1'b0)
    !resetn |=> pc == 5'h00 && !rx_push && !tx_pop && pin_data == 32'h0 && !stalled)
    else $error("outputs not cleared by reset");
  // ----------------------------------------
  // execution
  // ----------------------------------------
  chk_push_room: assert property (rx_push |-> !$past(rx_full))
    else $error("push issued into a full fifo");
  chk_push_single: assert property (rx_push |=> !rx_push)
    else $error("push pulses back to back");
  chk_pop_valid: assert property (tx_pop |-> tx_valid)
    else $error("pop from an empty fifo");
  chk_stall_holds_pc: assert property (stalled |=> $stable(pc))
    else $error("pc moved while stalled");
  chk_stall_quiet: assert property (stalled |-> !tx_pop && irq_clear == 8'h00)
    else $error("side effect while stalled");
  chk_clear_set_flag: assert property (irq_clear != 8'h00 |->
    $onehot(irq_clear) && (irq_clear & irq_flags) == irq_clear)
    else $error("irq clear not a single set flag");
  // pins only move after a cycle in which the machine was not stalled
  chk_pins_complete: assert property (!$stable(pin_data) |-> !$past(stalled))
    else $error("pins changed after a stalled cycle");
  cover property (rx_push);
  cover property (tx_pop);
  cover property (irq_clear != 8'h00);
  cover property (stalled ##1 !stalled);
endmodule // smwio_execute_target_checker

bind smwio_execute_target smwio_execute_target_checker smwio_execute_target_checker_inst (
  .clock(clock),
  .resetn(resetn),
  .paddr(paddr),
  .psel(psel),
  .penable(penable),
  .pslverr(pslverr),
  .pc(pc),
  .irq_flags(irq_flags),
  .irq_clear(irq_clear),
  .rx_push(rx_push),
  .rx_full(rx_full),
  .tx_valid(tx_valid),
  .tx_pop(tx_pop),
  .pin_data(pin_data),
  .stalled(stalled)
);

// >>> verification/smwio_far.sv
// far-side model: instruction store, fifo ends and irq flag set
// assumes the executor's clock; the bench fills prog and tx_words by hierarchy
module smwio_far (
  input wire clock,
  input wire resetn,
  input wire [4:0] pc,
  output logic [15:0] instr,
  output logic [7:0] irq_flags,
  input wire [7:0] irq_clear,
  input wire [7:0] irq_set,
  input wire [31:0] rx_data,
  input wire rx_push,
  input wire rx_block,
  output logic rx_full,
  output logic [31:0] tx_data,
  output logic tx_valid,
  input wire tx_pop
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] prog [0:31];
  logic [31:0] tx_words [0:1];
  logic [1:0] tx_idx;
  logic [31:0] rx_word;
  logic [3:0] rx_count;
  logic idle_flip;
  // ----------------------------------------
  // combinational answers
  // ----------------------------------------
  assign instr = prog[pc];
  // an empty fifo shows a flipping junk head, never its last word
  assign tx_valid = (tx_idx < 2'h2);
  assign tx_data = tx_valid ? tx_words[tx_idx[0]] : ({32{idle_flip}} ^ 32'h5A5A_5A5A);
  assign rx_full = rx_block;
  // fifo pointers and flags; flags drive the executor's irq_flags input
  always @(posedge clock) begin
    if (!resetn) begin
      tx_idx <= 2'h0;
      rx_count <= 4'h0;
      irq_flags <= 8'h00;
      idle_flip <= 1'b0;
    end else begin
      idle_flip <= ~idle_flip;
      if (tx_pop && tx_valid) begin
        tx_idx <= tx_idx + 2'h1;
      end
      if (rx_push) begin
        rx_word <= rx_data;
        rx_count <= rx_count + 4'h1;
      end
      irq_flags <= (irq_flags | irq_set) & ~irq_clear;
    end
  end
endmodule // smwio_far

// >>> verification/smwio_execute_target_bench.sv
// self-checking bench for the wait/in/out executor
// assumes the far-side model supplies program, fifo ends and irq flags
`include "smwio_defs.vh"
module smwio_execute_target_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] HALT = 16'h209F;
  localparam logic [15:0] PROG [0:8] = '{16'h6028, 16'h6050, 16'h4024, 16'h4044,
    16'h2085, 16'h20BE, 16'h20D1, 16'h6008, 16'h70F0};
  logic clock, resetn, psel, penable, pwrite, rx_block, err;
  logic [7:0] paddr, irq_set;
  logic [31:0] pwdata, gpio_in, rd;
  wire [31:0] prdata, rx_data, tx_data, pin_data, pin_dir;
  wire pready, pslverr, rx_push, rx_full, tx_valid, tx_pop, stalled;
  wire [4:0] pc;
  wire [15:0] instr;
  wire [7:0] irq_flags, irq_clear;
  int n_errors, samples_checked;

  smwio_execute_target smwio_execute_target_inst (.clock(clock), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pc(pc), .instr(instr), .gpio_in(gpio_in), .irq_flags(irq_flags),
    .irq_clear(irq_clear), .rx_data(rx_data), .rx_push(rx_push), .rx_full(rx_full),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_pop(tx_pop), .pin_data(pin_data),
    .pin_dir(pin_dir), .stalled(stalled));
  smwio_far smwio_far_inst (.clock(clock), .resetn(resetn), .pc(pc), .instr(instr),
    .irq_flags(irq_flags), .irq_clear(irq_clear), .irq_set(irq_set), .rx_data(rx_data),
    .rx_push(rx_push), .rx_block(rx_block), .rx_full(rx_full), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_pop(tx_pop));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one transfer, entered just after a rising edge; request held until pready
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (i >= 50) begin
      n_errors++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  // bounded wait until the machine stalls on a given instruction word;
  // looks mid-cycle where outputs are settled, returns just after a rising edge
  task automatic wait_on(input logic [15:0] w);
    int i;
    for (i = 0; i < 400; i++) begin
      @(negedge clock);
      if (stalled === 1'b1 && instr === w) break;
    end
    if (i >= 400) begin
      n_errors++;
      stop_test();
    end
    @(posedge clock);
  endtask

  // ----------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // a hang ends in the same closing report
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    stop_test();
  end
  initial begin
    resetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    gpio_in = 32'h0;
    irq_set = 8'h00;
    rx_block = 1'b1;
    n_errors = 0;
    samples_checked = 0;
    for (int k = 0; k < 32; k++) smwio_far_inst.prog[k] = (k < 9) ? PROG[k] : HALT;
    // out pc, 8 at both words after the inline one; it jumps to word 18
    smwio_far_inst.prog[9] = 16'h60A8;
    smwio_far_inst.prog[10] = 16'h60A8;
    smwio_far_inst.tx_words[0] = 32'h8765_43A5;
    smwio_far_inst.tx_words[1] = 32'h1234_6028;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    apb(1'b0, `SMWIO_REG_CONFIG, 32'h0);
    check(rd, 32'h0000_0018); // reset value of the config word
    apb(1'b0, 6'h0A, 32'h0);
    check({31'h0, err}, 32'h1); // unmapped index answers with an error
    check(rd, 32'h0);
    apb(1'b1, `SMWIO_REG_THRESH, 32'h0000_0008);
    apb(1'b1, `SMWIO_REG_PINCFG, 32'h0000_2005);
    apb(1'b1, `SMWIO_REG_CONFIG, 32'h0000_0217);
    // second in must wait while the rx fifo reports full
    wait_on(16'h4044);
    repeat (5) @(posedge clock);
    check({27'h0, pc}, 32'h3);
    check({28'h0, smwio_far_inst.rx_count}, 32'h0);
    rx_block <= 1'b0;
    wait_on(16'h2085);
    apb(1'b0, `SMWIO_REG_ISR, 32'h0);
    check(rd, 32'h0);
    check(smwio_far_inst.rx_word, 32'h0000_0053);
    apb(1'b0, `SMWIO_REG_STATUS, 32'h0);
    check(rd & 32'h0001_FFE0, 32'h0000_C000);
    gpio_in <= 32'h0000_0020;
    wait_on(16'h20BE);
    gpio_in <= 32'h0000_0028;
    wait_on(16'h20D1);
    // flag 1 is the unshifted index; machine 2 must wait on flag 3
    irq_set <= 8'h02;
    @(posedge clock);
    irq_set <= 8'h00;
    repeat (8) @(posedge clock);
    check({16'h0, instr}, 32'h0000_20D1);
    irq_set <= 8'h08;
    @(posedge clock);
    irq_set <= 8'h00;
    wait_on(HALT);
    check({24'h0, irq_flags}, 32'h0000_0002);
    check({30'h0, smwio_far_inst.tx_idx}, 32'h2);
    check({27'h0, pc}, 32'h0000_0012);
    apb(1'b0, `SMWIO_REG_SCRATCH_X, 32'h0);
    check(rd, 32'h0000_0034);
    apb(1'b0, `SMWIO_REG_SCRATCH_Y, 32'h0);
    check(rd, 32'h0000_6543);
    apb(1'b0, `SMWIO_REG_PIN_DATA, 32'h0);
    check(rd, 32'h0000_0087);
    check(pin_dir, 32'h0000_0000);
    stop_test();
  end
endmodule // smwio_execute_target_bench
